//--- inc/hlp_regs.svh
`ifndef HLP_REGS_SVH
`define HLP_REGS_SVH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define HLP_OFF_REQ      4'h0
`define HLP_OFF_RESULT   4'h4
`define HLP_OFF_ALLOC    4'h8
`define HLP_OFF_LOCKS    4'hC
`define HLP_OFF_IRQ_STAT 5'h10
`define HLP_OFF_IRQ_MASK 5'h14

// ****************************************************************
// request word fields
// ****************************************************************
`define HLP_REQ_SRC_LSB   0
`define HLP_REQ_ID_LSB    4
`define HLP_REQ_CORE_LSB  8
`define HLP_REQ_WZ_BIT    12
`define HLP_REQ_WC_BIT    13
`define HLP_REQ_WR_BIT    14
`define HLP_REQ_INSTR_LSB 16

// ****************************************************************
// encodings and reset values
// ****************************************************************
`define HLP_INSTR_HUB     6'h03
`define HLP_SRC_ALLOC     3'h4
`define HLP_SRC_RELEASE   3'h5
`define HLP_SRC_SET       3'h6
`define HLP_SRC_CLEAR     3'h7
`define HLP_ALLOC_RST     8'h00
`define HLP_LOCKS_RST     8'h00
`define HLP_MASK_RST      2'h0

// ****************************************************************
// timing
// ****************************************************************
`define HLP_MIN_CLOCKS    5'h08
`define HLP_MAX_CLOCKS    5'h17
`define HLP_SLOT_CLOCKS   2'h2
`define HLP_NUM_CORES     8

`endif

//--- inc/hlp_pkg.sv
package hlp_pkg;
    typedef enum logic [1:0] {
        HLP_OP_ALLOC,
        HLP_OP_RELEASE,
        HLP_OP_SET,
        HLP_OP_CLEAR
    } hlp_op_t;

    typedef enum logic [1:0] {
        HLP_ST_IDLE,
        HLP_ST_WAIT,
        HLP_ST_EXEC,
        HLP_ST_DONE
    } hlp_state_t;
endpackage : hlp_pkg

//--- src/hlp_slot_wheel.sv
`timescale 1ns/1ps
`include "hlp_regs.svh"

// round-robin hub slot wheel: one core owns the hub per slot
module hlp_slot_wheel (
    input  wire logic       core_clk,   // system clock
    input  wire logic       rst_n,      // async reset, active low
    output logic      [2:0] slot_core,  // core that owns this slot
    output logic            slot_start  // first cycle of a slot
);
    logic [1:0] sub_cnt;
    wire        sub_last = (sub_cnt == (`HLP_SLOT_CLOCKS - 2'h1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_cnt <= 2'h0;
            slot_core <= 3'h0;
        end else if (sub_last) begin
            sub_cnt <= 2'h0;
            slot_core <= slot_core + 3'h1;
        end else begin
            sub_cnt <= sub_cnt + 2'h1;
        end
    end

    assign slot_start = (sub_cnt == 2'h0);
endmodule : hlp_slot_wheel

//--- src/hlp_free_finder.sv
`timescale 1ns/1ps

// lowest-numbered free lock, with a none-free indication
module hlp_free_finder (
    input  wire logic [7:0] alloc,      // allocation bitmap
    output logic      [2:0] free_id,    // lowest clear index
    output logic            none_free   // all allocated
);
    logic [7:0] cand;
    logic [7:0] lower_free;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pri
            if (i == 0) begin : g_first
                assign lower_free[i] = 1'b0;
            end else begin : g_rest
                assign lower_free[i] = lower_free[i-1] | ~alloc[i-1];
            end
            assign cand[i] = ~alloc[i] & ~lower_free[i];
        end
    endgenerate

    assign free_id = {|cand[7:4], |{cand[7:6], cand[3:2]},
                      |{cand[7], cand[5], cand[3], cand[1]}};
    assign none_free = &alloc;
endmodule : hlp_free_finder

//--- src/hlp_lock_pool.sv
`timescale 1ns/1ps
`include "hlp_regs.svh"

// What this block does
// - allocate reserves a free lock, returns 0..7
// - allocate carry set when none free
// - allocate zero set when returned id zero
// - allocate writes id unless no-result
// - allocate decoded by 000011 and source 4
// - release marks addressed lock unallocated
// - release carry set if all were allocated
// - release zero set when id zero
// - release encoded 000011, source 5
// - only low three id bits are used
// - set drives lock bit, carry returns old
// - set zero flag when id zero
// - set encoded by source 6
// - release/set write id only on write-result
// - each operation completes in 8 to 23 clocks
// - clear, source 7, zeroes bit, returns old

// ****************************************************************
// lock pool with avalon-mm register access
// ****************************************************************
module hlp_lock_pool (
    input  wire logic        core_clk,         // system clock
    input  wire logic        rst_n,            // async reset, active low
    input  wire logic [4:0]  avs_address,      // byte address
    input  wire logic        avs_read,         // read strobe
    input  wire logic        avs_write,        // write strobe
    input  wire logic [31:0] avs_writedata,    // write data
    input  wire logic [3:0]  avs_byteenable,   // byte lanes
    output logic      [31:0] avs_readdata,     // read data
    output logic             avs_waitrequest,  // stall
    output logic             irq               // level interrupt
);

    // ************************************************************
    // state
    // ************************************************************
    hlp_pkg::hlp_state_t state;
    hlp_pkg::hlp_op_t    op;
    logic [7:0] alloc;
    logic [7:0] locks;
    logic [2:0] req_id;
    logic [2:0] req_core;
    logic       opt_wz;
    logic       opt_wc;
    logic       opt_wr;
    logic [4:0] cyc;
    logic       busy;
    logic       zero_flag;
    logic       carry_flag;
    logic       result_valid;
    logic [2:0] allocated_id_dest;
    logic       dest_written;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic       bad_req;

    // ************************************************************
    // slot wheel and free-lock search
    // ************************************************************
    logic [2:0] slot_core;
    logic       slot_start;
    logic [2:0] free_id;
    logic       none_free;

    hlp_slot_wheel u_wheel (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .slot_core  (slot_core),
        .slot_start (slot_start)
    );

    hlp_free_finder u_find (
        .alloc     (alloc),
        .free_id   (free_id),
        .none_free (none_free)
    );

    // ************************************************************
    // bus decode
    // ************************************************************
    wire sel_req    = (avs_address == {1'b0, `HLP_OFF_REQ});
    wire sel_result = (avs_address == {1'b0, `HLP_OFF_RESULT});
    wire sel_alloc  = (avs_address == {1'b0, `HLP_OFF_ALLOC});
    wire sel_locks  = (avs_address == {1'b0, `HLP_OFF_LOCKS});
    wire sel_stat   = (avs_address == `HLP_OFF_IRQ_STAT);
    wire sel_mask   = (avs_address == `HLP_OFF_IRQ_MASK);

    // waitrequest is a flop that idles high: each access sees one
    // wait cycle, and readdata has that cycle to settle in a flop
    wire  acc      = (avs_read | avs_write) & avs_waitrequest;
    wire  wr_take  = avs_write & acc & avs_byteenable[0];

    wire [5:0] w_instr = avs_writedata[`HLP_REQ_INSTR_LSB +: 6];
    wire [2:0] w_src   = avs_writedata[`HLP_REQ_SRC_LSB +: 3];
    wire       w_isrc  = avs_writedata[`HLP_REQ_SRC_LSB + 3];
    // only three id bits are kept, so id 8 is lock 0
    wire [2:0] w_id    = avs_writedata[`HLP_REQ_ID_LSB +: 3];
    wire       w_wr    = avs_writedata[`HLP_REQ_WR_BIT];
    // source 0..3 is not a lock operation
    wire       w_hub   = (w_instr == `HLP_INSTR_HUB) & w_src[2]
                         & ~w_isrc;
    wire       issue   = wr_take & sel_req & ~busy & w_hub;
    wire       reject  = wr_take & sel_req & (busy | ~w_hub);

    hlp_pkg::hlp_op_t w_op;
    assign w_op = (w_src == `HLP_SRC_ALLOC)   ? hlp_pkg::HLP_OP_ALLOC :
                  (w_src == `HLP_SRC_RELEASE) ? hlp_pkg::HLP_OP_RELEASE :
                  (w_src == `HLP_SRC_SET)     ? hlp_pkg::HLP_OP_SET :
                                                hlp_pkg::HLP_OP_CLEAR;

    // ************************************************************
    // execution timing
    // ************************************************************
    // the window opens at the next slot start owned by the core,
    // but never before the minimum hub latency has elapsed
    wire at_window = slot_start & (slot_core == req_core);
    wire can_exec  = at_window
                     & (cyc >= (`HLP_MIN_CLOCKS - 5'h2));
    wire exec_now  = (state == hlp_pkg::HLP_ST_WAIT) & can_exec;
    wire done_now  = (state == hlp_pkg::HLP_ST_EXEC)
                     & (cyc >= (`HLP_MIN_CLOCKS - 5'h1));

    assign busy = (state != hlp_pkg::HLP_ST_IDLE)
                  & (state != hlp_pkg::HLP_ST_DONE);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= hlp_pkg::HLP_ST_IDLE;
            cyc <= 5'h00;
        end else begin
            case (state)
                hlp_pkg::HLP_ST_IDLE,
                hlp_pkg::HLP_ST_DONE: begin
                    if (issue) begin
                        state <= hlp_pkg::HLP_ST_WAIT;
                        cyc <= 5'h01;
                    end
                end
                hlp_pkg::HLP_ST_WAIT: begin
                    cyc <= cyc + 5'h01;
                    if (can_exec) begin
                        state <= hlp_pkg::HLP_ST_EXEC;
                    end
                end
                hlp_pkg::HLP_ST_EXEC: begin
                    cyc <= cyc + 5'h01;
                    if (done_now) begin
                        state <= hlp_pkg::HLP_ST_DONE;
                    end
                end
                default: state <= hlp_pkg::HLP_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op <= hlp_pkg::HLP_OP_ALLOC;
            req_id <= 3'h0;
            req_core <= 3'h0;
            opt_wz <= 1'b0;
            opt_wc <= 1'b0;
            opt_wr <= 1'b0;
        end else if (issue) begin
            op <= w_op;
            req_id <= w_id;
            req_core <= avs_writedata[`HLP_REQ_CORE_LSB +: 3];
            opt_wz <= avs_writedata[`HLP_REQ_WZ_BIT];
            opt_wc <= avs_writedata[`HLP_REQ_WC_BIT];
            // result bit clear is the no-result option, for every op
            opt_wr <= w_wr;
        end
    end

    // ************************************************************
    // atomic read-modify-write in the owning slot
    // ************************************************************
    wire is_alloc = (op == hlp_pkg::HLP_OP_ALLOC);
    wire is_rel   = (op == hlp_pkg::HLP_OP_RELEASE);
    wire is_set   = (op == hlp_pkg::HLP_OP_SET);
    wire [2:0] res_id   = is_alloc ? (none_free ? 3'h7 : free_id)
                                   : req_id;
    wire       res_c    = is_alloc ? none_free
                        : is_rel   ? &alloc
                        : locks[req_id];
    wire       res_z    = (res_id == 3'h0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alloc <= `HLP_ALLOC_RST;
            locks <= `HLP_LOCKS_RST;
        end else if (exec_now) begin
            if (is_alloc & ~none_free) begin
                alloc[free_id] <= 1'b1;
            end else if (is_rel) begin
                alloc[req_id] <= 1'b0;
            end else if (is_set) begin
                locks[req_id] <= 1'b1;
            end else if (!is_alloc) begin
                locks[req_id] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag <= 1'b0;
            carry_flag <= 1'b0;
            allocated_id_dest <= 3'h0;
            dest_written <= 1'b0;
            result_valid <= 1'b0;
        end else if (exec_now) begin
            if (opt_wz) begin
                zero_flag <= res_z;
            end
            if (opt_wc) begin
                carry_flag <= res_c;
            end
            // destination untouched unless a write is due
            if (opt_wr) begin
                allocated_id_dest <= res_id;
            end
            dest_written <= opt_wr;
            result_valid <= 1'b0;
        end else if (done_now) begin
            result_valid <= 1'b1;
        end else if (issue) begin
            result_valid <= 1'b0;
        end
    end

    // ************************************************************
    // interrupt: bit 0 done, bit 1 refused request
    // ************************************************************
    wire       rd_stat = avs_read & acc & sel_stat;
    wire [1:0] ev      = {reject, done_now};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 2'h0;
            irq_mask <= `HLP_MASK_RST;
            irq <= 1'b0;
            bad_req <= 1'b0;
        end else begin
            // a new event in the clearing read survives
            irq_stat <= (rd_stat ? 2'h0 : irq_stat) | ev;
            if (wr_take & sel_mask) begin
                irq_mask <= avs_writedata[1:0];
            end
            irq <= |(((rd_stat ? 2'h0 : irq_stat) | ev) & irq_mask);
            if (reject) begin
                bad_req <= 1'b1;
            end else if (issue) begin
                bad_req <= 1'b0;
            end
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    wire [31:0] rd_mux =
        sel_req    ? {29'h0, bad_req, busy, result_valid} :
        sel_result ? {24'h0, dest_written, carry_flag, zero_flag,
                      2'h0, allocated_id_dest} :
        sel_alloc  ? {24'h0, alloc} :
        sel_locks  ? {24'h0, locks} :
        sel_stat   ? {30'h0, irq_stat} :
        sel_mask   ? {30'h0, irq_mask} : 32'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= ~acc;
            if (avs_read & acc) begin
                avs_readdata <= rd_mux;
            end
        end
    end

endmodule : hlp_lock_pool

//--- sim/hlp_lock_pool_monitor.sv
`timescale 1ns/1ps
`include "hlp_regs.svh"

// ****************************************************************
// port checker for the lock pool
// ****************************************************************
module hlp_lock_pool_monitor (
    input wire logic        core_clk,        // system clock
    input wire logic        rst_n,           // async reset, active low
    input wire logic [4:0]  avs_address,     // byte address
    input wire logic        avs_read,        // read strobe
    input wire logic        avs_write,       // write strobe
    input wire logic [31:0] avs_writedata,   // write data
    input wire logic [3:0]  avs_byteenable,  // byte lanes
    input wire logic [31:0] avs_readdata,    // read data
    input wire logic        avs_waitrequest, // stall
    input wire logic        irq              // level interrupt
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic       in_acc;
    logic [1:0] mask_q;
    logic       clr_q;
    wire        acc   = avs_read | avs_write;
    wire        done  = acc & ~avs_waitrequest;
    wire        first = acc & ~in_acc;
    wire        mwr   = done & avs_write & avs_address == `HLP_OFF_IRQ_MASK;
    // status is cleared in the first cycle of the read, mask moves
    // while the write stands
    wire        srd   = first & avs_read & avs_address == `HLP_OFF_IRQ_STAT;
    wire        clr   = srd | acc & avs_write
                        & avs_address == `HLP_OFF_IRQ_MASK;
    // only well-formed requests start an operation
    wire        go    = done & avs_write & avs_address == 5'h00
                      & avs_writedata[21:16] == 6'h03
                      & avs_writedata[3:2] == 2'b01;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_acc <= 1'b0;
            mask_q <= 2'h0;
            clr_q  <= 1'b0;
        end else begin
            in_acc <= acc & avs_waitrequest;
            clr_q  <= clr;
            if (mwr)
                mask_q <= avs_writedata[1:0];
        end
    end

    // go is seen one edge after the design takes the request
    sequence quiet_s;
        !irq [*7];
    endsequence
    sequence raise_s;
        ##[0:15] irq;
    endsequence

    wait_first_a: assert property (first |-> avs_waitrequest)
        else $error("no wait state in first cycle");
    wait_one_a: assert property (first |=> !avs_waitrequest)
        else $error("access not answered after one wait");
    idle_wait_a: assert property (!acc |-> avs_waitrequest)
        else $error("answer given while idle");
    done_window_a:
        assert property (go && mask_q[0] && !irq |-> quiet_s ##1 raise_s)
        else $error("operation done outside 8 to 23 clocks");
    irq_off_a: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0
                                |-> !irq)
        else $error("interrupt while fully masked");
    irq_hold_a: assert property (irq && !clr && !clr_q |=> irq)
        else $error("interrupt dropped without clear");
    unmapped_zero_a: assert property (done && avs_read
                                      && avs_address > 5'h14
                                      |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    reset_quiet_a:
        assert property ($rose(rst_n) |-> avs_readdata == 32'h0 && !irq)
        else $error("outputs not quiet after reset");
    rd_stable_a: assert property ($changed(avs_readdata)
                                  |-> $past(avs_read && avs_waitrequest))
        else $error("read data moved without a read");
endmodule : hlp_lock_pool_monitor

bind hlp_lock_pool hlp_lock_pool_monitor i_hlp_lock_pool_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq)
);

//--- sim/hlp_core_host.sv
`timescale 1ns/1ps

// ****************************************************************
// bus master standing in for the issuing cores
// ****************************************************************
module hlp_core_host (
    input  wire logic        core_clk,        // system clock
    output logic      [4:0]  avs_address,     // byte address
    output logic             avs_read,        // read strobe
    output logic             avs_write,       // write strobe
    output logic      [31:0] avs_writedata,   // write data
    output logic      [3:0]  avs_byteenable,  // byte lanes
    input  wire logic [31:0] avs_readdata,    // read data
    input  wire logic        avs_waitrequest  // stall
);
    initial begin
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end

    task automatic acc(input logic is_rd, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= is_rd;
        avs_write     <= !is_rd;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // stale data after release must never look valid
        avs_writedata <= ~d;
    endtask : acc
endmodule : hlp_core_host

//--- sim/testbench.sv
`timescale 1ns/1ps
`include "hlp_regs.svh"

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %0t got %0h exp %0h", $time, g, e); \
    end end

module testbench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic [31:0] q;
    int          bad_count = 0;
    int          check_count = 0;
    // src, id, flags {wr,wc,wz}, expected result, compare mask
    localparam logic [27:0] TAB [9] = '{28'h587E0E7, 28'h40160E7,
        28'h55260E7, 28'h53220E7, 28'h65785E7, 28'h657C5E7,
        28'h687A0E7, 28'h757C5E7, 28'h75205E7};

    always #5 core_clk = ~core_clk;

    hlp_lock_pool i_hlp_lock_pool (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq));
    hlp_core_host host (
        .core_clk(core_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        host.acc(1'b1, a, 32'h0, d);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        host.acc(1'b0, a, d, x);
    endtask : wr

    task automatic op(input logic [27:0] t, input logic [2:0] core);
        logic [31:0] s;
        do rd(5'h00, s); while (s[1] !== 1'b0);
        wr(5'h00, {10'h000, 6'h03, 1'b0, t[18:16], 1'b0, core,
                   t[23:20], 1'b0, t[26:24]});
        do rd(5'h00, s); while (s[1:0] !== 2'b01);
        rd(5'h04, s);
        `CHK(s[7:0] & t[7:0], t[15:8])
        rd(5'h10, s);
        `CHK(s[1:0], 2'h1)
    endtask : op

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(5'h08, q);
        `CHK(q, 32'h0)
        rd(5'h0C, q);
        `CHK(q, 32'h0)
        rd(5'h14, q);
        `CHK(q, 32'h0)
        wr(5'h14, 32'h1);
        for (int i = 0; i < 9; i++) begin
            op({4'h4, 4'h0, 4'h7, (i < 8) ? {2'b10, i == 0, 2'b00,
                i[2:0]} : 8'hC7, 8'hE7}, i[2:0]);
        end
        rd(5'h08, q);
        `CHK(q, 32'hFF)
        for (int i = 0; i < 9; i++) begin
            op(TAB[i], i[2:0]);
            if (i == 6) begin
                rd(5'h0C, q);
                `CHK(q, 32'h21)
            end
        end
        rd(5'h08, q);
        `CHK(q, 32'hD7)
        rd(5'h0C, q);
        `CHK(q, 32'h01)
        wr(5'h14, 32'h0);
        wr(5'h00, 32'h0003_0026);
        wr(5'h00, 32'h0003_0036);
        rd(5'h00, q);
        `CHK(q[2:0], 3'h6)
        do rd(5'h00, q); while (q[1] !== 1'b0);
        rd(5'h0C, q);
        `CHK(q, 32'h05)
        rd(5'h10, q);
        `CHK(q[1:0], 2'h3)
        wr(5'h14, 32'h1);
        wr(5'h00, 32'h0004_0004);
        rd(5'h00, q);
        `CHK(q[2], 1'b1)
        `CHK(irq, 1'b0)
        wr(5'h14, 32'h3);
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b1)
        rd(5'h10, q);
        `CHK(q[1:0], 2'h2)
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b0)
        rd(5'h18, q);
        `CHK(q, 32'h0)
        results();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        results();
    end
endmodule : testbench
